// File: core/close_onto_fault_zone_enable.sv
// Close-onto-fault and trip-on-reclose zone enable with APB registers.
// Assumes breaker, pole and pickup inputs are synchronous to mclk_i.
//
// Operation
// - Mode three arms from either the dead-pole timer or the external pulse.
// - External-pulse mode arms from the pulse input, not dead-pole timing.
// - Pick-up timer starts with all poles open; 0.2..1000 s, default 110 s.
// - Arm close-onto-fault only for closure after timer expiry or a seen pulse.
// - Closures made by auto-reclose never arm close-onto-fault.
// - Five-bit close-onto-fault zone mask, default 00001.
// - Mask bits: zone1, zone2, zone3, programmable zone, zone4.
// - Masked zone in pickup at closure trips without its time delay.
// - Such trips are three-phase and block auto-reclose.
// - Trip-on-reclose arms 200 ms after opening when enabled only.
// - Separate five-bit reclose zone mask, default 00001.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ns
module close_onto_fault_zone_enable
	import onto_fault_pkg::*;
#(
	parameter int ARM_STEP_CYCLES = STEP_CYCLES
) (
	input  wire logic          mclk_i,      // 20 MHz clock.
	input  wire logic          rst_i,       // Sync reset, high.
	input  wire logic          psel_i,      // APB select.
	input  wire logic          penable_i,   // APB enable.
	input  wire logic          pwrite_i,    // APB write.
	input  wire logic [7:0]    paddr_i,     // APB byte address.
	input  wire logic [31:0]   pwdata_i,    // APB write data.
	output logic [31:0]        prdata_o,    // APB read data.
	output logic               pready_o,    // APB ready.
	output logic               pslverr_o,   // APB error.
	input  wire logic          cb_closed_i, // Breaker closed.
	input  wire logic          poles_dead_i,// All three poles open.
	input  wire logic          ext_pulse_i, // External arming pulse.
	input  wire logic          ar_close_i,  // Closure by auto-reclose.
	input  wire logic [NZ-1:0] pickup_i,    // Zone pickups.
	output logic [NZ-1:0]      inst_trip_o, // Instant trip per zone.
	output logic               trip_3ph_o,  // Three-phase trip.
	output logic               ar_block_o,  // Auto-reclose block.
	output logic               irq_o        // Interrupt, level.
);
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	// Each register is one aligned 32-bit word; reserved bits read 0.
	//   0x00 control : [1:0] arming source (0 off, 1 dead pole,
	//                  2 pulse, 3 both), [2] trip-on-reclose enable.
	//   0x04 delay   : [12:0] arming delay in 0.2 s steps, 1 to 5000;
	//                  writes outside that range are clamped.
	//   0x08 masks   : [4:0] close-onto-fault zones, [12:8] reclose zones.
	//   0x0c status  : write one to clear; [0] close-onto-fault trip,
	//                  [1] reclose trip, [2] close-onto-fault armed,
	//                  [3] reclose armed. A new event beats a clear.
	//   0x10 irq en  : same layout; a set bit lets its flag interrupt.
	//   0x14 state   : read only; [0] close-onto-fault live, [1] reclose
	//                  live, [2] pulse seen, [3] delay expired,
	//                  [4] reclose delay expired, [5] breaker closed.
	// Any other address answers with an error, reads 0 and is ignored.

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	arm_mode_t         arm_mode;
	logic              reclose_protection_enable;
	logic [STEP_W-1:0] onto_fault_arming_delay;
	logic [NZ-1:0]     onto_fault_zone_mask;
	logic [NZ-1:0]     reclose_zone_mask;
	logic [NEV-1:0]    status;
	logic [NEV-1:0]    irq_en;
	logic              cb_q;
	logic              ext_seen;
	logic              otf_live;
	logic              tor_live;
	logic              pd_done;
	logic              tor_done;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire acc      = psel_i & penable_i;
	wire wr_fire  = acc & pready_o & pwrite_i;
	wire sel_ctrl = (paddr_i == ADDR_CTRL);
	wire sel_dly  = (paddr_i == ADDR_DELAY);
	wire sel_msk  = (paddr_i == ADDR_MASKS);
	wire sel_sts  = (paddr_i == ADDR_STATUS);
	wire sel_ien  = (paddr_i == ADDR_IRQEN);
	wire sel_st   = (paddr_i == ADDR_STATE);
	wire mapped   = sel_ctrl | sel_dly | sel_msk | sel_sts | sel_ien | sel_st;
	wire [STEP_W-1:0] wr_dly = pwdata_i[STEP_W-1:0];

	// Delay writes are clamped, so a zero or oversize value cannot stall.
	function automatic logic [STEP_W-1:0] clamp_dly(input logic [STEP_W-1:0] v);
		if (v < DELAY_MIN)
			return DELAY_MIN;
		else if (v > DELAY_MAX)
			return DELAY_MAX;
		else
			return v;
	endfunction

	// ----------------------------------------------------------------
	// Arming logic
	// ----------------------------------------------------------------
	// The dead-pole delay runs while all poles are open in mode one or
	// three and restarts from zero whenever a pole recovers. A pulse
	// seen in mode two or three is held until the breaker reopens. A
	// closure is the rise of the breaker-closed input; if either source
	// is ready then and auto-reclose did not make the closure, the
	// close-onto-fault state is armed for as long as the breaker stays
	// closed. Otherwise the closure arms trip-on-reclose, provided its
	// one-step delay has run out since the opening. Only one state is
	// armed per closure, which keeps reclose blocking tied to manual
	// closes. The instant permissions are registered, so a pickup shows
	// at the outputs one cycle later; the zone elements themselves are
	// outside this block.
	wire pd_mode   = (arm_mode == MODE_PD) | (arm_mode == MODE_BOTH);
	wire ext_mode  = (arm_mode == MODE_EXT) | (arm_mode == MODE_BOTH);
	wire pd_run    = poles_dead_i & pd_mode;
	wire close_ev  = cb_closed_i & ~cb_q;
	wire open_ev   = ~cb_closed_i & cb_q;
	wire otf_ready = (pd_done & pd_mode) | (ext_seen & ext_mode);
	wire otf_arm   = close_ev & otf_ready & ~ar_close_i;
	wire tor_ready = tor_done & reclose_protection_enable;
	wire tor_arm   = close_ev & tor_ready & ~otf_arm;
	wire tor_run   = ~cb_closed_i & reclose_protection_enable;

	// Zone permission: pickup, mask bit and armed state.
	wire [NZ-1:0] otf_perm  = pickup_i & onto_fault_zone_mask & {NZ{otf_live}};
	wire [NZ-1:0] tor_perm  = pickup_i & reclose_zone_mask & {NZ{tor_live}};
	wire [NZ-1:0] next_trip = otf_perm | tor_perm;
	wire [NEV-1:0] events   = {tor_arm, otf_arm, |tor_perm, |otf_perm};

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	step_delay_timer #(.CYC(ARM_STEP_CYCLES)) u_pd_timer (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.run_i   (pd_run),
		.steps_i (onto_fault_arming_delay),
		.done_o  (pd_done)
	);

	step_delay_timer #(.CYC(ARM_STEP_CYCLES)) u_tor_timer (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.run_i   (tor_run),
		.steps_i (STEP_W'(TOR_STEPS)),
		.done_o  (tor_done)
	);

	// ----------------------------------------------------------------
	// Settings registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			arm_mode                  <= MODE_OFF;
			reclose_protection_enable <= 1'b1;
			onto_fault_arming_delay   <= DELAY_RST;
			onto_fault_zone_mask      <= ZMASK_RST;
			reclose_zone_mask         <= ZMASK_RST;
			irq_en                    <= '0;
		end else if (wr_fire) begin
			if (sel_ctrl) begin
				arm_mode                  <= arm_mode_t'(pwdata_i[MODE_LSB +: 2]);
				reclose_protection_enable <= pwdata_i[TOR_EN_BIT];
			end else if (sel_dly) begin
				onto_fault_arming_delay <= clamp_dly(wr_dly);
			end else if (sel_msk) begin
				onto_fault_zone_mask <= pwdata_i[OTF_M_LSB +: NZ];
				reclose_zone_mask    <= pwdata_i[TOR_M_LSB +: NZ];
			end else if (sel_ien) begin
				irq_en <= pwdata_i[NEV-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Armed states. Reopening ends them, so each closure is judged
	// afresh; there is no reset window, the state lasts while closed.
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cb_q     <= 1'b0;
			ext_seen <= 1'b0;
			otf_live <= 1'b0;
			tor_live <= 1'b0;
		end else begin
			cb_q <= cb_closed_i;
			if (open_ev || !ext_mode)
				ext_seen <= 1'b0;
			else if (ext_pulse_i)
				ext_seen <= 1'b1;
			if (open_ev || arm_mode == MODE_OFF)
				otf_live <= 1'b0;
			else if (otf_arm)
				otf_live <= 1'b1;
			if (open_ev || !reclose_protection_enable)
				tor_live <= 1'b0;
			else if (tor_arm)
				tor_live <= 1'b1;
		end
	end

	// Trip outputs; only close-onto-fault trips block reclosing.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			inst_trip_o <= '0;
			trip_3ph_o  <= 1'b0;
			ar_block_o  <= 1'b0;
		end else begin
			inst_trip_o <= next_trip;
			trip_3ph_o  <= |next_trip;
			ar_block_o  <= |otf_perm;
		end
	end

	// ----------------------------------------------------------------
	// Status and interrupt. A new event wins over a same-cycle clear.
	// ----------------------------------------------------------------
	wire [NEV-1:0] w1c = (wr_fire & sel_sts) ? pwdata_i[NEV-1:0] : '0;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			status <= '0;
			irq_o  <= 1'b0;
		end else begin
			status <= (status & ~w1c) | events;
			irq_o  <= |(((status & ~w1c) | events) & irq_en);
		end
	end

	// ----------------------------------------------------------------
	// APB answer: one wait state, read data and error registered.
	// ----------------------------------------------------------------
	wire [31:0] rd_ctrl = 32'({reclose_protection_enable, arm_mode});
	wire [31:0] rd_msk  = 32'({reclose_zone_mask, 3'h0, onto_fault_zone_mask});
	wire [31:0] rd_st   = 32'({cb_closed_i, tor_done, pd_done, ext_seen, tor_live, otf_live});
	wire [31:0] next_rd = sel_ctrl ? rd_ctrl :
	                      sel_dly  ? 32'(onto_fault_arming_delay) :
	                      sel_msk  ? rd_msk :
	                      sel_sts  ? 32'(status) :
	                      sel_ien  ? 32'(irq_en) :
	                      sel_st   ? rd_st : 32'h0000_0000;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= '0;
		end else begin
			pready_o  <= acc & ~pready_o;
			pslverr_o <= acc & ~pready_o & ~mapped;
			if (acc && !pready_o && !pwrite_i)
				prdata_o <= next_rd;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb_chk @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	chk_auto_close_no_arm: assert property (close_ev && ar_close_i |=> !otf_live)
		else $error("auto-reclose closure armed close-onto-fault");
	chk_early_close_no_arm: assert property (close_ev && !otf_ready |=> !otf_live)
		else $error("closure before arming became active");
	chk_ext_mode_pulse: assert property (arm_mode == MODE_EXT && ext_pulse_i && !open_ev |=> ext_seen)
		else $error("external pulse did not arm");
	chk_pd_ignored_ext: assert property (arm_mode == MODE_EXT |-> !otf_ready || ext_seen)
		else $error("dead-pole timing armed in pulse mode");
	chk_both_sources: assert property (arm_mode == MODE_BOTH && pd_done |-> otf_ready)
		else $error("dead-pole source ignored in mode three");
	chk_reopen_clears: assert property (open_ev |=> !otf_live && !tor_live)
		else $error("armed state survived reopening");
	chk_perm_and: assert property (##1 inst_trip_o == $past(next_trip))
		else $error("zone permission mismatch");
	chk_trip_three_phase: assert property (|inst_trip_o |-> trip_3ph_o)
		else $error("zone trip without three-phase trip");
	chk_switch_onto_fault_blocks_ar: assert property (|otf_perm |=> ar_block_o && trip_3ph_o)
		else $error("close-onto-fault trip did not block reclose");
	chk_zone1_default: assert property (
		$rose(otf_live) && onto_fault_zone_mask == ZMASK_RST && pickup_i[0] |=> inst_trip_o[0])
		else $error("zone one not tripped with default mask");
	chk_tor_disabled: assert property (!reclose_protection_enable |=> !tor_live)
		else $error("reclose protection active while disabled");
	chk_delay_range: assert property (
		onto_fault_arming_delay >= DELAY_MIN && onto_fault_arming_delay <= DELAY_MAX)
		else $error("arming delay out of range");

	// Zone permission needs its pickup, its mask bit and an armed state.
	chk_trip_needs_pick: assert property (##1 (inst_trip_o & ~$past(pickup_i)) == '0)
		else $error("zone trip without its pickup");
	chk_trip_needs_arm: assert property (!otf_live && !tor_live |=> inst_trip_o == '0)
		else $error("zone trip while nothing is armed");
	chk_trip_needs_mask: assert property (
		##1 (inst_trip_o & ~($past(onto_fault_zone_mask) | $past(reclose_zone_mask))) == '0)
		else $error("zone trip outside both masks");
	chk_otf_instant: assert property (otf_live && (pickup_i & onto_fault_zone_mask) != '0 |=> trip_3ph_o)
		else $error("masked zone in pickup did not trip at once");
	chk_tor_instant: assert property (tor_live && (pickup_i & reclose_zone_mask) != '0 |=> trip_3ph_o)
		else $error("reclose zone in pickup did not trip at once");
	chk_block_only_otf: assert property (!otf_live |=> !ar_block_o)
		else $error("reclose blocked without close-onto-fault");

	// Arming sources and timers; both timers start from zero each opening.
	chk_off_mode_idle: assert property (arm_mode == MODE_OFF |=> !otf_live)
		else $error("close-onto-fault armed with arming off");
	chk_pd_mode_no_ext: assert property (arm_mode == MODE_PD |=> !ext_seen)
		else $error("pulse latched in dead-pole mode");
	chk_pd_restart: assert property (!pd_run |=> !pd_done)
		else $error("dead-pole delay expired while not timing");
	chk_pd_not_early: assert property ($rose(pd_run) |=> !pd_done)
		else $error("dead-pole delay expired at once");
	chk_tor_restart: assert property (cb_closed_i |=> !tor_done)
		else $error("reclose delay expired with breaker closed");
	chk_tor_not_early: assert property ($rose(tor_run) |=> !tor_done)
		else $error("reclose delay expired at once");
	chk_tor_needs_timer: assert property (close_ev && !tor_done |=> !tor_live)
		else $error("reclose armed before its delay");

	// Bus answer and interrupt.
	chk_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready held for two cycles");
	chk_err_with_ready: assert property (pslverr_o |-> pready_o)
		else $error("error flagged without ready");
	chk_status_from_perm: assert property (|otf_perm |=> status[0])
		else $error("close-onto-fault trip not flagged");
	chk_status_sticky: assert property (status[0] && !(wr_fire && sel_sts && pwdata_i[0]) |=> status[0])
		else $error("status flag lost without a clear");
	chk_irq_follows: assert property ((status & irq_en) != '0 && !wr_fire |=> irq_o)
		else $error("enabled status flag without interrupt");
	chk_irq_needs_en: assert property (irq_en == '0 |=> !irq_o)
		else $error("interrupt with every source masked");

	cov_otf_trip: cover property (otf_live ##1 |otf_perm);
	cov_tor_trip: cover property (tor_live ##1 |tor_perm);
	cov_ext_arm:  cover property (ext_seen && otf_arm);
	cov_irq:      cover property ($rose(irq_o));
	cov_early_close: cover property (close_ev && pd_mode && !pd_done);
endmodule

// File: core/onto_fault_pkg.sv
// Shared constants for the close-onto-fault zone enable block.
// Assumes a 20 MHz system clock and 32-bit APB register access.
package onto_fault_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int MCLK_HZ      = 20_000_000;
	localparam int STEP_MS      = 200;
	localparam int STEP_CYCLES  = MCLK_HZ / 1000 * STEP_MS;
	localparam int TOR_DELAY_MS = 200;
	localparam int TOR_STEPS    = TOR_DELAY_MS / STEP_MS;
	localparam int STEP_W       = 13;
	localparam logic [STEP_W-1:0] DELAY_MIN = 13'h0001;
	localparam logic [STEP_W-1:0] DELAY_MAX = 13'h1388;
	localparam logic [STEP_W-1:0] DELAY_RST = 13'h0226;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_DELAY  = 8'h04;
	localparam logic [7:0] ADDR_MASKS  = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_IRQEN  = 8'h10;
	localparam logic [7:0] ADDR_STATE  = 8'h14;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int NZ         = 5;
	localparam int MODE_LSB   = 0;
	localparam int TOR_EN_BIT = 2;
	localparam int OTF_M_LSB  = 0;
	localparam int TOR_M_LSB  = 8;
	localparam int NEV        = 4;
	localparam logic [NZ-1:0] ZMASK_RST = 5'h01;

	typedef enum logic [1:0] {
		MODE_OFF  = 2'b00,
		MODE_PD   = 2'b01,
		MODE_EXT  = 2'b10,
		MODE_BOTH = 2'b11
	} arm_mode_t;

endpackage

// File: core/step_delay_timer.sv
// Pick-up timer counting whole 0.2 s steps while its run input is high.
// Assumes run falls to restart it; the step target is held stable.
`timescale 1ns/1ns
module step_delay_timer
	import onto_fault_pkg::*;
#(
	parameter int CYC = STEP_CYCLES
) (
	input  wire logic              mclk_i,  // System clock.
	input  wire logic              rst_i,   // Synchronous reset.
	input  wire logic              run_i,   // Timing while high.
	input  wire logic [STEP_W-1:0] steps_i, // Steps to expiry.
	output logic                   done_o   // Expired, level.
);
	logic [31:0]       cyc;
	logic [STEP_W-1:0] steps;
	wire               step_end  = (cyc == 32'(CYC - 1));
	wire               reached   = (steps >= steps_i);
	wire               next_done = run_i & reached;

	// ----------------------------------------------------------------
	// Counters restart whenever run drops, so a short dead time
	// never accumulates across separate openings.
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i || !run_i) begin
			cyc   <= '0;
			steps <= '0;
		end else if (step_end) begin
			cyc <= '0;
			if (!reached)
				steps <= steps + 1'b1;
		end else begin
			cyc <= cyc + 1'b1;
		end
	end

	// Registered expiry flag.
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			done_o <= 1'b0;
		else
			done_o <= next_done;
	end
endmodule

// File: bench/close_onto_fault_zone_enable_bench.sv
// Self-checking bench for the close-onto-fault zone enable block.
// Assumes the onto_fault_pkg package is compiled first; short arming steps keep the run brief.
`timescale 1ns/1ns
module close_onto_fault_zone_enable_bench
	import onto_fault_pkg::*;
;

	// ----------------------------------------------------------------
	// Signals and instance
	// ----------------------------------------------------------------
	localparam int ASC = 4;
	typedef struct packed {
		logic [1:0] mode;
		logic       ext;
		logic [7:0] wt;
		logic       arc;
		logic [4:0] pick;
		logic [4:0] mask;
		logic [4:0] exp;
	} row_t;
	logic          mclk_i = 1'b0;
	logic          rst_i = 1'b1;
	logic          psel_i = 1'b0;
	logic          penable_i = 1'b0;
	logic          pwrite_i = 1'b0;
	logic [7:0]    paddr_i = 8'h00;
	logic [31:0]   pwdata_i = 32'h0;
	logic [31:0]   prdata_o;
	logic          pready_o;
	logic          pslverr_o;
	logic          cb_closed_i = 1'b0;
	logic          poles_dead_i = 1'b0;
	logic          ext_pulse_i = 1'b0;
	logic          ar_close_i = 1'b0;
	logic [NZ-1:0] pickup_i = 5'h00;
	logic [NZ-1:0] inst_trip_o;
	logic          trip_3ph_o;
	logic          ar_block_o;
	logic          irq_o;
	logic [31:0]   rd;
	logic          err;
	int            num_errors = 0;
	int            checks_done = 0;
	// Each armed row has a non-zero expectation, so trip and block flags follow it.
	row_t rows [9] = '{
		'{2'd1, 1'b0, 8'd30, 1'b0, 5'h1f, 5'h01, 5'h01},
		'{2'd1, 1'b0, 8'd30, 1'b0, 5'h1f, 5'h02, 5'h02},
		'{2'd1, 1'b0, 8'd30, 1'b0, 5'h0a, 5'h1f, 5'h0a},
		'{2'd1, 1'b0, 8'd2,  1'b0, 5'h1f, 5'h1f, 5'h00},
		'{2'd1, 1'b0, 8'd30, 1'b1, 5'h1f, 5'h1f, 5'h00},
		'{2'd2, 1'b1, 8'd2,  1'b0, 5'h14, 5'h1c, 5'h14},
		'{2'd2, 1'b0, 8'd30, 1'b0, 5'h1f, 5'h1f, 5'h00},
		'{2'd3, 1'b1, 8'd30, 1'b0, 5'h18, 5'h10, 5'h10},
		'{2'd0, 1'b1, 8'd30, 1'b0, 5'h1f, 5'h1f, 5'h00}
	};

	close_onto_fault_zone_enable #(.ARM_STEP_CYCLES(ASC)) close_onto_fault_zone_enable_i (
		.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .cb_closed_i(cb_closed_i), .poles_dead_i(poles_dead_i),
		.ext_pulse_i(ext_pulse_i), .ar_close_i(ar_close_i), .pickup_i(pickup_i),
		.inst_trip_o(inst_trip_o), .trip_3ph_o(trip_3ph_o), .ar_block_o(ar_block_o), .irq_o(irq_o)
	);

	// The 20 MHz clock.
	always #25 mclk_i = ~mclk_i;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// One APB transfer; the wait for ready is bounded only by the watchdog.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		@(posedge mclk_i);
		while (pready_o !== 1'b1) begin
			@(posedge mclk_i);
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			num_errors++;
			$display("BAD t=%0t got %h want %h", $time, got, want);
		end
	endtask

	task automatic chk_pin(input logic [4:0] got, input logic [4:0] want);
		checks_done++;
		if (got !== want) begin
			num_errors++;
			$display("BAD t=%0t got %h want %h", $time, got, want);
		end
	endtask

	// Open with poles dead, optional pulse, wait, then close and raise pickups.
	task automatic energise(input logic ext, input logic [7:0] wt, input logic arc, input logic [4:0] pick);
		@(posedge mclk_i);
		poles_dead_i <= 1'b1;
		ext_pulse_i <= ext;
		pickup_i <= 5'h00;
		@(posedge mclk_i);
		ext_pulse_i <= 1'b0;
		repeat (wt) @(posedge mclk_i);
		cb_closed_i <= 1'b1;
		poles_dead_i <= 1'b0;
		ar_close_i <= arc;
		@(posedge mclk_i);
		pickup_i <= pick;
		repeat (2) @(posedge mclk_i);
		#1;
	endtask

	// Reopening must drop every permission even with pickups still present.
	task automatic reopen;
		@(posedge mclk_i);
		cb_closed_i <= 1'b0;
		ar_close_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		#1;
		chk_pin(inst_trip_o, 5'h00);
	endtask

	task automatic check_out(input logic [4:0] want, input logic blk);
		chk_pin(inst_trip_o, want);
		chk_pin({4'h0, trip_3ph_o}, {4'h0, |want});
		chk_pin({4'h0, ar_block_o}, {4'h0, blk});
	endtask

	task automatic wrap_up;
		if (num_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		check_out(5'h00, 1'b0);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk_reg(rd, 32'h4);
		apb(1'b0, ADDR_DELAY, 32'h0);
		chk_reg(rd, 32'h226);
		apb(1'b0, ADDR_MASKS, 32'h0);
		chk_reg(rd, 32'h101);
		apb(1'b1, ADDR_DELAY, 32'h0);
		apb(1'b0, ADDR_DELAY, 32'h0);
		chk_reg(rd, 32'h1);
		apb(1'b1, ADDR_DELAY, 32'h1fff);
		apb(1'b0, ADDR_DELAY, 32'h0);
		chk_reg(rd, 32'h1388);
		apb(1'b1, ADDR_CTRL, 32'hffffffff);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk_reg(rd, 32'h7);
		apb(1'b0, 8'h18, 32'h0);
		chk_reg({rd[31:1], err}, 32'h1);
		apb(1'b1, ADDR_DELAY, 32'h1);
		// Reclose stays disabled in the rows so only close-onto-fault arming shows.
		foreach (rows[k]) begin
			apb(1'b1, ADDR_CTRL, {30'h0, rows[k].mode});
			apb(1'b1, ADDR_MASKS, {27'h0, rows[k].mask});
			energise(rows[k].ext, rows[k].wt, rows[k].arc, rows[k].pick);
			check_out(rows[k].exp, |rows[k].exp);
			reopen;
		end
		// Trip-on-reclose with its own mask; the interrupt is masked first, then enabled.
		apb(1'b1, ADDR_STATUS, 32'hf);
		apb(1'b1, ADDR_IRQEN, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h4);
		apb(1'b1, ADDR_MASKS, 32'h041f);
		energise(1'b0, 8'd30, 1'b1, 5'h1f);
		check_out(5'h04, 1'b0);
		chk_pin({4'h0, irq_o}, 5'h00);
		apb(1'b1, ADDR_IRQEN, 32'h2);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk_reg(rd & 32'h2, 32'h2);
		@(posedge mclk_i);
		#1;
		chk_pin({4'h0, irq_o}, 5'h01);
		reopen;
		apb(1'b1, ADDR_STATUS, 32'h2);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk_reg(rd & 32'h2, 32'h0);
		@(posedge mclk_i);
		#1;
		chk_pin({4'h0, irq_o}, 5'h00);
		// A fresh opening shorter than the reclose delay must not arm it.
		@(posedge mclk_i);
		pickup_i <= 5'h00;
		cb_closed_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		cb_closed_i <= 1'b0;
		energise(1'b0, 8'd0, 1'b1, 5'h1f);
		check_out(5'h00, 1'b0);
		reopen;
		apb(1'b1, ADDR_CTRL, 32'h0);
		energise(1'b0, 8'd30, 1'b1, 5'h1f);
		check_out(5'h00, 1'b0);
		reopen;
		// Reset in mid-run, breaker closed, pickups present and masks changed.
		apb(1'b1, ADDR_MASKS, 32'h1f1f);
		@(posedge mclk_i);
		cb_closed_i <= 1'b1;
		rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		check_out(5'h00, 1'b0);
		chk_pin({4'h0, irq_o}, 5'h00);
		apb(1'b0, ADDR_MASKS, 32'h0);
		chk_reg(rd, 32'h101);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk_reg(rd, 32'h4);
		wrap_up;
	end

	// Watchdog: 20000 cycles, far beyond the several hundred cycles the sequence needs.
	initial begin
		#(50 * 20000);
		num_errors++;
		wrap_up;
	end
endmodule
